// *** verilog/swc_sleep_wakeup_controller.v ***
/*
  Sleep-mode wake-up and partial-wake clock request controller.
  Assumes wake sources, clock requests and oscillator ready flags arrive
  from other domains; interrupt lines come from logic on aclk.
*/
// Implementation choices: the register addresses and register access over AXI4-Lite.
`include "swc_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module swc_sleep_wakeup_controller #(
  parameter NP = 8,
  parameter NG = 4,
  parameter NS = 4,
  parameter NA = 8,
  parameter NI = 8
) (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave.
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt lines, already masked.
  input wire [NI-1:0] irq_hsb,
  input wire [NI-1:0] irq_pb,
  // Asynchronous wake sources.
  input wire async_realtime_counter_wake,
  input wire watchdog_unit_wake,
  input wire watchdog_on_crystal_32k,
  input wire external_irq_unit_wake,
  input wire ext_reset_wake,
  input wire wake_n,
  input wire [NA-1:0] async_wake,
  // Asynchronous clock requests and oscillator ready flags.
  input wire [NP-1:0] pb_clk_req,
  input wire [NG-1:0] gclk_req,
  input wire [NS-1:0] osc_ready,
  // Clock gating outputs.
  output reg cpu_clk_en,
  output reg high_speed_bus_clk_en,
  output reg intc_clk_en,
  output reg [NP-1:0] peripheral_bus_clk_en,
  output reg [NG-1:0] gclk_en,
  output reg [NS-1:0] osc_en,
  output reg partial_wake_state
);

  localparam ST_RUN = `SWC_ST_RUN;
  localparam ST_SLEEP = `SWC_ST_SLEEP;
  localparam ST_WALK = `SWC_ST_WALK;
  localparam SW = NP + NG + NS + NA + 5;

  function [NS-1:0] src_onehot;
    input [1:0] sel;
    begin
      src_onehot = {NS{1'b0}};
      src_onehot[sel] = 1'b1;
    end
  endfunction

  // Two-flop synchronisers for all inputs from other domains.
  wire [SW-1:0] raw_in;
  reg [SW-1:0] meta_reg;
  reg [SW-1:0] sync_reg;
  assign raw_in = {pb_clk_req, gclk_req, osc_ready, async_wake,
    async_realtime_counter_wake, watchdog_unit_wake, external_irq_unit_wake,
    ext_reset_wake, wake_n};
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= {{(SW-1){1'b0}}, 1'b1};
      sync_reg <= {{(SW-1){1'b0}}, 1'b1};
    end else begin
      meta_reg <= raw_in;
      sync_reg <= meta_reg;
    end
  end

  wire [NP-1:0] pb_req_s = sync_reg[SW-1 -: NP];
  wire [NG-1:0] gclk_req_s = sync_reg[SW-NP-1 -: NG];
  wire [NS-1:0] osc_ready_s = sync_reg[SW-NP-NG-1 -: NS];
  wire [NA-1:0] awake_s = sync_reg[NA+4:5];
  wire rtc_s = sync_reg[4];
  wire wdt_s = sync_reg[3];
  wire eint_s = sync_reg[2];
  wire rst_s = sync_reg[1];
  wire wake_n_s = sync_reg[0];
  reg wdt_o32_meta_reg;
  reg wdt_o32_reg;

  // Software registers.
  reg [2:0] mode_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [NA-1:0] async_wake_enable_reg;
  reg [NP+NG-1:0] periph_power_ctrl_reg;
  reg [NP-1:0] pbclk_reg;
  reg [NG-1:0] gclk_reg;
  reg [1:0] src_reg;
  reg o32_reg;
  reg o32_entry_reg;

  // AXI write path.
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [4:0] waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_hold_reg || aw_take;
  wire w_have = w_hold_reg || w_take;
  wire [4:0] wa = aw_hold_reg ? waddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_hold_reg ? wdata_reg : s_axi_wdata;
  wire [3:0] ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;
  wire wr_do = aw_have && w_have && !s_axi_bvalid;
  wire wr_hit = (wa == `SWC_OFF_CTRL) || (wa == `SWC_OFF_ASYNC_WAKE_ENABLE) ||
    (wa == `SWC_OFF_PERIPH_POWER_CTRL) || (wa == `SWC_OFF_PBCLK) ||
    (wa == `SWC_OFF_GCLK) || (wa == `SWC_OFF_SRC);
  wire go = wr_do && (wa == `SWC_OFF_CTRL) && ws[1] && wd[`SWC_CTRL_GO] &&
    (state_reg == ST_RUN) && (wd[2:0] <= `SWC_MODE_SHUTDOWN);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SWC_RESP_OKAY;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      waddr_reg <= 5'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_bvalid;
      s_axi_wready <= !w_have && !s_axi_bvalid;
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; peripheral requests start unmasked.
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= `SWC_MODE_IDLE;
      async_wake_enable_reg <= {NA{1'b0}};
      periph_power_ctrl_reg <= {(NP+NG){1'b1}}; // [R13]
      pbclk_reg <= {NP{1'b1}};
      gclk_reg <= {NG{1'b0}};
      src_reg <= 2'h0;
      o32_reg <= 1'b0;
      o32_entry_reg <= 1'b0;
    end else begin
      if (go) begin
        mode_reg <= wd[2:0]; // [R03]
        o32_entry_reg <= o32_reg;
      end
      if (wr_do && ws[0]) begin
        if (wa == `SWC_OFF_ASYNC_WAKE_ENABLE)
          async_wake_enable_reg <= wd[NA-1:0];
        if (wa == `SWC_OFF_PERIPH_POWER_CTRL)
          periph_power_ctrl_reg <= wd[NP+NG-1:0]; // [R13]
        if (wa == `SWC_OFF_PBCLK)
          pbclk_reg <= wd[NP-1:0];
        if (wa == `SWC_OFF_GCLK)
          gclk_reg <= wd[NG-1:0];
        if (wa == `SWC_OFF_SRC) begin
          src_reg <= wd[1:0];
          o32_reg <= wd[`SWC_SRC_O32];
        end
      end
    end
  end

  // AXI read path.
  reg [31:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `SWC_OFF_CTRL: rd_mux[2:0] = mode_reg;
      `SWC_OFF_STATUS: begin
        rd_mux[1:0] = state_reg;
        rd_mux[6:4] = mode_reg;
        rd_mux[8] = sync_reg[0];
      end
      `SWC_OFF_ASYNC_WAKE_ENABLE: rd_mux[NA-1:0] = async_wake_enable_reg;
      `SWC_OFF_PERIPH_POWER_CTRL: rd_mux[NP+NG-1:0] = periph_power_ctrl_reg;
      `SWC_OFF_PBCLK: rd_mux[NP-1:0] = pbclk_reg;
      `SWC_OFF_GCLK: rd_mux[NG-1:0] = gclk_reg;
      `SWC_OFF_SRC: begin
        rd_mux[1:0] = src_reg;
        rd_mux[`SWC_SRC_O32] = o32_reg;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SWC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `SWC_RESP_OKAY : `SWC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Wake decision.
  wire [2:0] mode_eff = go ? wd[2:0] : mode_reg;
  wire deep = (mode_eff >= `SWC_MODE_STANDBY);
  wire shut = (mode_eff == `SWC_MODE_SHUTDOWN);
  wire wdt_ok = wdt_s && ((mode_reg != `SWC_MODE_STATIC) ||
    (wdt_o32_reg && o32_entry_reg)); // [R06]
  wire async_any = rtc_s || wdt_ok || eint_s || rst_s || !wake_n_s ||
    (|(awake_s & async_wake_enable_reg)); // [R02]
  wire shut_wake = rst_s || !wake_n_s || rtc_s; // [R07]
  wire sync_wake = (mode_reg == `SWC_MODE_IDLE) ? (|irq_hsb || |irq_pb) :
    (mode_reg == `SWC_MODE_FROZEN) ? |irq_pb : 1'b0; // [R01] [R04] [R05]
  wire full_wake = shut ? shut_wake : (async_any || sync_wake); // [R04]
  wire [NP-1:0] pb_want = pb_req_s & periph_power_ctrl_reg[NP-1:0]; // [R13]
  wire [NG-1:0] g_want = gclk_req_s & periph_power_ctrl_reg[NP+NG-1:NP]; // [R10]
  wire any_want = |pb_want || |g_want;
  wire irq_pend = |irq_hsb || |irq_pb;
  wire src_up = |(osc_ready_s & src_onehot(src_reg)); // [R11]

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: if (go) state_next = ST_SLEEP;
      ST_SLEEP: begin
        if (full_wake)
          state_next = ST_RUN; // [R16]
        else if (deep && !shut && any_want)
          state_next = irq_pend ? ST_RUN : ST_WALK; // [R08] [R14]
      end
      ST_WALK: begin
        if (async_any || irq_pend)
          state_next = ST_RUN; // [R12] [R14]
        else if (!any_want)
          state_next = ST_SLEEP;
      end
      default: state_next = ST_RUN;
    endcase
  end

  // Per-clock grants wait for the source to be running.
  wire [NP-1:0] pb_grant;
  wire [NG-1:0] g_grant;
  genvar i;
  generate
    for (i = 0; i < NP; i = i + 1) begin : g_pb
      assign pb_grant[i] = pb_want[i] && src_up; // [R09] [R11]
    end
    for (i = 0; i < NG; i = i + 1) begin : g_gc
      assign g_grant[i] = g_want[i] && src_up; // [R10] [R11]
    end
  endgenerate

  wire run_n = (state_next == ST_RUN);
  wire sleep_n = (state_next == ST_SLEEP);
  wire walk_n = (state_next == ST_WALK);
  wire light = (mode_eff <= `SWC_MODE_FROZEN);
  wire [NS-1:0] o32_mask = o32_reg ? ({{(NS-1){1'b0}}, 1'b1} <<
    `SWC_O32_IDX) : {NS{1'b0}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_RUN;
      wdt_o32_meta_reg <= 1'b0;
      wdt_o32_reg <= 1'b0;
      cpu_clk_en <= 1'b1;
      high_speed_bus_clk_en <= 1'b1;
      intc_clk_en <= 1'b1;
      peripheral_bus_clk_en <= {NP{1'b0}};
      gclk_en <= {NG{1'b0}};
      osc_en <= {NS{1'b0}};
      partial_wake_state <= 1'b0;
    end else begin
      state_reg <= state_next;
      wdt_o32_meta_reg <= watchdog_on_crystal_32k;
      wdt_o32_reg <= wdt_o32_meta_reg;
      cpu_clk_en <= run_n; // [R16]
      high_speed_bus_clk_en <= run_n ||
        (sleep_n && mode_eff == `SWC_MODE_IDLE); // [R05]
      intc_clk_en <= run_n || walk_n || (sleep_n && light); // [R14]
      partial_wake_state <= walk_n;
      if (run_n) begin
        peripheral_bus_clk_en <= pbclk_reg | pb_grant; // [R12] [R16]
        gclk_en <= gclk_reg | g_grant;
        osc_en <= src_onehot(src_reg) | o32_mask;
      end else if (walk_n) begin
        peripheral_bus_clk_en <= pb_grant; // [R09]
        gclk_en <= g_grant; // [R10]
        osc_en <= src_onehot(src_reg) | o32_mask; // [R09]
      end else if (light) begin
        peripheral_bus_clk_en <= pbclk_reg; // [R05]
        gclk_en <= gclk_reg;
        osc_en <= src_onehot(src_reg) | o32_mask;
      end else begin
        peripheral_bus_clk_en <= {NP{1'b0}};
        gclk_en <= {NG{1'b0}};
        osc_en <= shut ? {NS{1'b0}} : o32_mask; // [R06]
      end
    end
  end

endmodule

`default_nettype wire

// *** verilog/swc_consts.vh ***
/*
  Constants of the sleep and wake-up controller: register offsets, field
  positions, bus response codes, sleep mode indices and controller states.
  Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
*/
// Function
// [R01] Every non-masked interrupt is a synchronous wake source in accepting modes.
// [R02] Realtime counter, watchdog, external irqs, reset, wake pin, enabled async wakes wake.
// [R03] Sleep command carries mode index 0 idle through 6 shutdown; that mode entered.
// [R04] Modes 0 and 1 wake on both kinds; modes 2 to 5 async only.
// [R05] Frozen stops high-speed bus clocks; only peripheral bus interrupts wake it.
// [R06] In static mode watchdog wakes only if clocked from pre-enabled 32k crystal.
// [R07] Shutdown wakes only on external reset, wake pin or realtime counter.
// [R08] Peripheral clock request partially wakes modes stopping bus clocks, except shutdown.
// [R09] Partial wake starts only requested clocks and their source; others stay zero.
// [R10] Generic clocks are startable by the same request mechanism.
// [R11] A requested clock is delivered only after its source finished startup.
// [R12] Async wake during partial wake fully wakes without stopping granted clocks.
// [R13] Each request maskable in periph_power_ctrl; all unmasked after reset.
// [R14] Interrupt controller clock runs in partial wake; pending interrupt wakes fully.
// [R15] Software disables externally communicating modules before entering sleep.
// [R16] Full wake restores all clocks enabled before sleep and resumes the processor.
`ifndef SWC_CONSTS_VH
`define SWC_CONSTS_VH

`define SWC_OFF_CTRL 5'h00
`define SWC_OFF_STATUS 5'h04
`define SWC_OFF_ASYNC_WAKE_ENABLE 5'h08
`define SWC_OFF_PERIPH_POWER_CTRL 5'h0C
`define SWC_OFF_PBCLK 5'h10
`define SWC_OFF_GCLK 5'h14
`define SWC_OFF_SRC 5'h18

`define SWC_CTRL_GO 8
`define SWC_SRC_O32 4
`define SWC_O32_IDX 0

`define SWC_MODE_IDLE 3'h0
`define SWC_MODE_FROZEN 3'h1
`define SWC_MODE_STANDBY 3'h2
`define SWC_MODE_STATIC 3'h5
`define SWC_MODE_SHUTDOWN 3'h6

`define SWC_ST_RUN 2'h0
`define SWC_ST_SLEEP 2'h1
`define SWC_ST_WALK 2'h2

`define SWC_RESP_OKAY 2'h0
`define SWC_RESP_SLVERR 2'h2

`endif

// *** testbench/swc_osc_model.sv ***
/*
  Oscillator model on the far side of the controller.
  Assumes osc_en requests a start and ready follows after SU + 1 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module swc_osc_model #(parameter int NS = 4, parameter int SU = 6) (
  // Clock.
  input wire logic aclk,
  // Start requests and startup flags.
  input wire logic [NS-1:0] osc_en,
  output var logic [NS-1:0] osc_ready = '0
);
  int cnt [NS];
  // A source reports ready only after its startup time has elapsed.
  always @(posedge aclk) begin
    for (int i = 0; i < NS; i++) begin
      cnt[i] <= osc_en[i] ? ((cnt[i] < SU) ? cnt[i] + 1 : SU) : 0;
      osc_ready[i] <= osc_en[i] && (cnt[i] == SU);
    end
  end
endmodule
`default_nettype wire

// *** testbench/swc_chk.sv ***
/*
  Checker of the sleep and wake-up controller ports.
  Assumes it is bound into the controller and sees its ports only.
*/
`include "swc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module swc_chk #(parameter NP = 8, parameter NS = 4, parameter NI = 8) (
  // Clock, reset and write channels.
  input wire aclk,
  input wire aresetn,
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [1:0] s_axi_bresp,
  // Wake side.
  input wire [NI-1:0] irq_hsb,
  input wire [NI-1:0] irq_pb,
  input wire [NP-1:0] pb_clk_req,
  input wire [NS-1:0] osc_ready,
  // Clock enables.
  input wire cpu_clk_en,
  input wire high_speed_bus_clk_en,
  input wire intc_clk_en,
  input wire [NP-1:0] peripheral_bus_clk_en,
  input wire [NS-1:0] osc_en,
  input wire partial_wake_state
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_go;
    wr_both ##0 s_axi_awaddr == `SWC_OFF_CTRL && s_axi_wdata[8] && s_axi_wstrb[1] && cpu_clk_en;
  endsequence
  a_sleep_entry: assert property (wr_go ##0 s_axi_wdata[2:0] < 3'h7 |=> !cpu_clk_en)
    else $error("processor clock kept after sleep command");
  a_idle_hsb: assert property (wr_go ##0 s_axi_wdata[2:0] == 3'h0 |=> high_speed_bus_clk_en)
    else $error("bus clock stopped in idle");
  a_frozen_hsb: assert property (wr_go ##0 s_axi_wdata[2:0] == 3'h1 |=> !high_speed_bus_clk_en)
    else $error("bus clock running in frozen");
  a_idle_wake: assert property (!cpu_clk_en && high_speed_bus_clk_en && !partial_wake_state
    && |irq_hsb |=> cpu_clk_en) else $error("interrupt did not wake idle");
  a_frozen_wake: assert property (!cpu_clk_en && !high_speed_bus_clk_en && !partial_wake_state
    && |peripheral_bus_clk_en && |irq_pb |=> cpu_clk_en) else $error("no wake in frozen");
  a_walk_gate: assert property (partial_wake_state |-> !cpu_clk_en && intc_clk_en)
    else $error("wrong clocks in partial wake");
  a_walk_only: assert property (partial_wake_state |-> (peripheral_bus_clk_en & ~($past(pb_clk_req, 2)
    | $past(pb_clk_req, 3) | $past(pb_clk_req, 4))) == 0) else $error("unrequested clock");
  a_walk_osc: assert property (partial_wake_state && |peripheral_bus_clk_en |->
    |(osc_en & osc_ready)) else $error("clock before source ready");
  a_walk_keep: assert property ($fell(partial_wake_state) && cpu_clk_en |->
    ($past(peripheral_bus_clk_en) & ~peripheral_bus_clk_en) == 0) else $error("granted clock lost");
  a_bad_addr: assert property (wr_both ##0 s_axi_awaddr > `SWC_OFF_SRC |=>
    s_axi_bvalid && s_axi_bresp == `SWC_RESP_SLVERR) else $error("unmapped write accepted");
endmodule
bind swc_sleep_wakeup_controller swc_chk #(.NP(NP), .NS(NS), .NI(NI)) u_chk (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .irq_hsb, .irq_pb, .pb_clk_req, .osc_ready,
  .cpu_clk_en, .high_speed_bus_clk_en, .intc_clk_en, .peripheral_bus_clk_en, .osc_en,
  .partial_wake_state);
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
  Testbench of the sleep and wake-up controller.
  Assumes the oscillator model answers every start request.
*/
`include "swc_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SU = 6;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, wake_n = 1, async_realtime_counter_wake = 0;
  logic watchdog_unit_wake = 0, watchdog_on_crystal_32k = 0;
  logic external_irq_unit_wake = 0, ext_reset_wake = 0;
  logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rv;
  logic [3:0] s_axi_wstrb = 0, gclk_req = 0;
  logic [7:0] irq_hsb = 0, irq_pb = 0, async_wake = 0, pb_clk_req = 0;
  logic [1:0] rr;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_clk_en;
  wire high_speed_bus_clk_en, intc_clk_en, partial_wake_state;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] peripheral_bus_clk_en;
  wire [3:0] gclk_en, osc_en, osc_ready;
  int err_count = 0, checked = 0;
  always #20 aclk = ~aclk;
  swc_sleep_wakeup_controller u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_hsb, .irq_pb, .async_realtime_counter_wake,
    .watchdog_unit_wake, .watchdog_on_crystal_32k, .external_irq_unit_wake, .ext_reset_wake,
    .wake_n, .async_wake, .pb_clk_req, .gclk_req, .osc_ready, .cpu_clk_en,
    .high_speed_bus_clk_en, .intc_clk_en, .peripheral_bus_clk_en, .gclk_en, .osc_en,
    .partial_wake_state);
  swc_osc_model #(.NS(4), .SU(SU)) u_osc (.aclk, .osc_en, .osc_ready);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bit ta;
    bit tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge aclk);
    err_count++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    cy(2);
    rd(`SWC_OFF_PERIPH_POWER_CTRL);
    chk(rv, 32'h00000FFF);
    rd(5'h1C);
    chk(rr, `SWC_RESP_SLVERR);
    rd(`SWC_OFF_STATUS);
    chk(rv, 32'h00000100);
    wr(5'h1C, 32'h00000000);
    wr(`SWC_OFF_ASYNC_WAKE_ENABLE, 32'h00000001);
    $display("test registers done");
    wr(`SWC_OFF_CTRL, 32'h00000100);
    chk({cpu_clk_en, high_speed_bus_clk_en}, 2'h1);
    irq_hsb <= 8'h01;
    cy(2);
    chk(cpu_clk_en, 1);
    irq_hsb <= 0;
    wr(`SWC_OFF_CTRL, 32'h00000101);
    chk(high_speed_bus_clk_en, 0);
    irq_hsb <= 8'h01;
    cy(4);
    chk(cpu_clk_en, 0);
    irq_hsb <= 0;
    irq_pb <= 8'h01;
    cy(2);
    chk(cpu_clk_en, 1);
    irq_pb <= 0;
    $display("test shallow modes done");
    for (int m = 2; m < 7; m++) begin
      cy(5);
      wr(`SWC_OFF_CTRL, 32'h00000100 + m);
      irq_pb <= 8'h01;
      cy(5);
      chk(cpu_clk_en, 0);
      irq_pb <= 0;
      watchdog_unit_wake <= 1;
      cy(5);
      chk(cpu_clk_en, m < 5);
      watchdog_unit_wake <= 0;
      if (m < 6) async_wake <= 8'h01;
      else wake_n <= 0;
      cy(5);
      chk(cpu_clk_en, 1);
      async_wake <= 0;
      wake_n <= 1;
    end
    wr(`SWC_OFF_SRC, 32'h00000010);
    watchdog_on_crystal_32k <= 1;
    cy(3);
    wr(`SWC_OFF_CTRL, 32'h00000105);
    chk(osc_en, 4'h1);
    watchdog_unit_wake <= 1;
    cy(5);
    chk(cpu_clk_en, 1);
    watchdog_unit_wake <= 0;
    wr(`SWC_OFF_SRC, 32'h00000000);
    $display("test deep modes done");
    cy(5);
    wr(`SWC_OFF_CTRL, 32'h00000102);
    pb_clk_req <= 8'h04;
    cy(SU + 8);
    chk({partial_wake_state, cpu_clk_en, intc_clk_en}, 3'h5);
    chk(peripheral_bus_clk_en, 8'h04);
    chk(osc_en, 4'h1);
    async_realtime_counter_wake <= 1;
    cy(5);
    chk(cpu_clk_en, 1);
    chk(peripheral_bus_clk_en, 8'hFF);
    async_realtime_counter_wake <= 0;
    pb_clk_req <= 0;
    cy(5);
    wr(`SWC_OFF_PERIPH_POWER_CTRL, 32'h00000FFB);
    wr(`SWC_OFF_CTRL, 32'h00000103);
    pb_clk_req <= 8'h04;
    cy(SU + 8);
    chk(partial_wake_state, 0);
    gclk_req <= 4'h2;
    cy(SU + 8);
    chk(gclk_en, 4'h2);
    chk(peripheral_bus_clk_en, 8'h00);
    gclk_req <= 0;
    cy(6);
    irq_pb <= 8'h01;
    pb_clk_req <= 8'h01;
    cy(6);
    chk(cpu_clk_en, 1);
    $display("test partial wake done");
    close_out;
  end
endmodule
`default_nettype wire
